// [common/mmcc_pkg.sv]
package mmcc_pkg;
	localparam int NUM_CH     = 8;
	localparam int CNT_W      = 16;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int PCLK_HZ    = 50_000_000;
	localparam int SRC_MAX_HZ = 20_000_000;

	// channel window: addr[7] low, addr[6:4] channel, addr[3:0] register
	localparam int CH_REGION_BIT = 7;
	localparam int CH_IDX_LSB    = 4;
	localparam int CH_IDX_W      = 3;
	localparam logic [3:0] OFS_MODE  = 4'h0;
	localparam logic [3:0] OFS_LOAD  = 4'h4;
	localparam logic [3:0] OFS_HOLD  = 4'h8;
	localparam logic [3:0] OFS_COUNT = 4'hC;
	localparam logic [7:0] OFS_CTRL   = 8'h80;
	localparam logic [7:0] OFS_STATUS = 8'h84;
	localparam logic [7:0] OFS_MASK   = 8'h88;

	// control word: arm bits low byte, disarm / run bits next byte
	localparam int ARM_LSB    = 0;
	localparam int DISARM_LSB = 8;

	localparam logic [3:0] GATE_NONE  = 4'h0;
	localparam logic [3:0] GATE_LEVEL = 4'h1;
	localparam logic [3:0] GATE_EDGE  = 4'h2;

	localparam logic [15:0] END_VALUE = 16'h0001;
	localparam logic [15:0] CNT_STEP  = 16'h0001;
	localparam logic [15:0] VAL_RST   = 16'h0000;
	localparam logic [7:0]  BYTE_RST  = 8'h00;

	typedef struct packed {
		logic [3:0] gate_control_field;
		logic [4:0] rsvd_hi;
		logic       special_gate_bit;
		logic       reload_source_select;
		logic       repetition_select;
		logic [3:0] rsvd_lo;
	} mmcc_mode_t;

	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_WAIT = 2'b01,
		CH_RUN  = 2'b10
	} mmcc_state_t;

	typedef struct packed {
		mmcc_state_t state;
		logic [15:0] count;
		logic        alt_hold;
		logic        end_seen;
	} mmcc_chan_t;

	localparam mmcc_mode_t MODE_RST = 16'h0000;
	localparam mmcc_chan_t CHAN_RST = '{CH_IDLE, 16'h0000, 1'h0, 1'h0};
endpackage

// [core/mmcc_counter.sv]
module mmcc_counter (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  cnt_src,
	input  wire logic [7:0]  gate_in,
	output logic      [7:0]  end_pulse,
	output logic             irq
);
	mmcc_pkg::mmcc_mode_t mode     [mmcc_pkg::NUM_CH];
	logic [15:0]          load_reg [mmcc_pkg::NUM_CH];
	logic [15:0]          hold_reg [mmcc_pkg::NUM_CH];
	mmcc_pkg::mmcc_chan_t chan     [mmcc_pkg::NUM_CH];
	mmcc_pkg::mmcc_chan_t next_chan[mmcc_pkg::NUM_CH];
	logic [7:0]           end_status;
	logic [7:0]           end_mask;
	logic [7:0]           src_q;
	logic [7:0]           gate_q;
	logic [7:0]           end_hit;
	logic [7:0]           accept;
	logic [7:0]           arm_wr;
	logic [7:0]           disarm_wr;
	logic [7:0]           w1c;
	logic [7:0]           armed;
	logic [7:0]           running;
	logic                 ack;
	logic                 wr_ok;
	logic [31:0]          next_prdata;
	logic                 next_err;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// one channel register at a given offset
	function automatic logic chan_hit(
		input logic [7:0] a,
		input logic [2:0] ch,
		input logic [3:0] ofs
	);
		return !a[mmcc_pkg::CH_REGION_BIT]
			&& a[mmcc_pkg::CH_IDX_LSB +: mmcc_pkg::CH_IDX_W] == ch
			&& a[mmcc_pkg::CH_IDX_LSB-1:0] == ofs;
	endfunction

	// apb answer: one wait cycle so read data is registered before pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack <= 1'h0;
		end else if (ce) begin
			ack <= psel & penable & ~ack;
		end
	end

	// ce low stalls the answer, so a write never lands in a frozen cycle
	assign pready = ack & ce;
	assign wr_ok  = psel & penable & pwrite & pready;

	// read mux; anything outside the map answers with an error
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_err    = 1'h1;
		for (int k = 0; k < mmcc_pkg::NUM_CH; k++) begin
			if (chan_hit(paddr, 3'(k), mmcc_pkg::OFS_MODE)) begin
				next_prdata = {16'h0000, mode[k]};
				next_err    = 1'h0;
			end
			if (chan_hit(paddr, 3'(k), mmcc_pkg::OFS_LOAD)) begin
				next_prdata = {16'h0000, load_reg[k]};
				next_err    = 1'h0;
			end
			if (chan_hit(paddr, 3'(k), mmcc_pkg::OFS_HOLD)) begin
				next_prdata = {16'h0000, hold_reg[k]};
				next_err    = 1'h0;
			end
			if (chan_hit(paddr, 3'(k), mmcc_pkg::OFS_COUNT)) begin
				next_prdata = {16'h0000, chan[k].count};
				next_err    = 1'h0;
			end
		end
		if (paddr == mmcc_pkg::OFS_CTRL) begin
			next_prdata = {16'h0000, running, armed};
			next_err    = 1'h0;
		end
		if (paddr == mmcc_pkg::OFS_STATUS) begin
			next_prdata = {24'h000000, end_status};
			next_err    = 1'h0;
		end
		if (paddr == mmcc_pkg::OFS_MASK) begin
			next_prdata = {24'h000000, end_mask};
			next_err    = 1'h0;
		end
	end

	// read data and error caught on the first access cycle, held to pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'h0;
		end else if (ce && psel && penable && !ack) begin
			prdata  <= next_prdata;
			pslverr <= next_err;
		end
	end

	// per-channel configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < mmcc_pkg::NUM_CH; k++) begin
				mode[k]     <= mmcc_pkg::MODE_RST;
				load_reg[k] <= mmcc_pkg::VAL_RST;
				hold_reg[k] <= mmcc_pkg::VAL_RST;
			end
		end else if (ce && wr_ok) begin
			for (int k = 0; k < mmcc_pkg::NUM_CH; k++) begin
				if (chan_hit(paddr, 3'(k), mmcc_pkg::OFS_MODE)) begin
					mode[k] <= pwdata[15:0];
				end
				if (chan_hit(paddr, 3'(k), mmcc_pkg::OFS_LOAD)) begin
					load_reg[k] <= pwdata[15:0];
				end
				if (chan_hit(paddr, 3'(k), mmcc_pkg::OFS_HOLD)) begin
					hold_reg[k] <= pwdata[15:0];
				end
			end
		end
	end

	// interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			end_mask <= mmcc_pkg::BYTE_RST;
		end else if (ce && wr_ok && paddr == mmcc_pkg::OFS_MASK) begin
			end_mask <= pwdata[7:0];
		end
	end

	// control strobes, valid only in the completing bus cycle
	always_comb begin
		arm_wr    = 8'h00;
		disarm_wr = 8'h00;
		w1c       = 8'h00;
		if (wr_ok && paddr == mmcc_pkg::OFS_CTRL) begin
			arm_wr    = pwdata[mmcc_pkg::ARM_LSB +: 8];
			disarm_wr = pwdata[mmcc_pkg::DISARM_LSB +: 8];
		end
		if (wr_ok && paddr == mmcc_pkg::OFS_STATUS) begin
			w1c = pwdata[7:0];
		end
	end

	// sticky status: a new event beats a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			end_status <= mmcc_pkg::BYTE_RST;
		end else if (ce) begin
			end_status <= (end_status & ~w1c) | end_hit;
		end
	end

	assign irq = |(end_status & end_mask);

	// input history for edge detection; pins are already synchronous
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q  <= 8'h00;
			gate_q <= 8'h00;
			end_pulse <= 8'h00;
		end else if (ce) begin
			src_q  <= cnt_src;
			gate_q <= gate_in;
			end_pulse <= end_hit;
		end
	end

	genvar i;
	generate
		for (i = 0; i < mmcc_pkg::NUM_CH; i++) begin : g_ch
			logic src_edge;
			logic gate_edge;
			logic gate_ok;
			logic done;
			logic sw;
			logic [3:0] gsel;
			logic rsel;
			logic rep;

			// special gate bit is not decoded; software keeps it clear
			assign gsel = mode[i].gate_control_field;
			assign rsel = mode[i].reload_source_select;
			assign rep  = mode[i].repetition_select;
			assign sw   = arm_wr[i] | disarm_wr[i];

			// rising edge per pclk: 50 MHz sampling covers a 20 MHz source
			assign src_edge  = cnt_src[i] & ~src_q[i];
			assign gate_edge = gate_in[i] & ~gate_q[i];

			// unknown gate codes behave as ungated
			always_comb begin
				unique case (gsel)
					mmcc_pkg::GATE_LEVEL: gate_ok = gate_in[i];
					mmcc_pkg::GATE_EDGE:  gate_ok = 1'h1;
					default:              gate_ok = 1'h1;
				endcase
			end

			assign accept[i] = ce & src_edge & gate_ok
				& (chan[i].state == mmcc_pkg::CH_RUN);
			assign end_hit[i] = accept[i]
				& (chan[i].count == mmcc_pkg::END_VALUE);
			// last terminal count of the sequence: first, or second if alternating
			assign done = ~rsel | chan[i].end_seen;
			assign armed[i]   = chan[i].state != mmcc_pkg::CH_IDLE;
			assign running[i] = chan[i].state == mmcc_pkg::CH_RUN;

			// channel sequencing; software arm and disarm take priority
			always_comb begin
				next_chan[i] = chan[i];
				if (end_hit[i]) begin
					// alternate: after the load period comes the hold period
					if (rsel) begin
						next_chan[i].count = chan[i].alt_hold ?
							load_reg[i] : hold_reg[i];
						next_chan[i].alt_hold = ~chan[i].alt_hold;
					end else begin
						next_chan[i].count = load_reg[i];
					end
					next_chan[i].end_seen = ~done;
					if (!rep && done) begin
						next_chan[i].state = mmcc_pkg::CH_IDLE;
					end else if (gsel == mmcc_pkg::GATE_EDGE && done) begin
						next_chan[i].state = mmcc_pkg::CH_WAIT;
					end
				end else if (accept[i]) begin
					next_chan[i].count = chan[i].count - mmcc_pkg::CNT_STEP;
				end
				if (chan[i].state == mmcc_pkg::CH_WAIT && gate_edge
					&& gsel == mmcc_pkg::GATE_EDGE) begin
					next_chan[i].state    = mmcc_pkg::CH_RUN;
					next_chan[i].end_seen = 1'h0;
				end
				if (arm_wr[i]) begin
					next_chan[i].state = (gsel == mmcc_pkg::GATE_EDGE) ?
						mmcc_pkg::CH_WAIT : mmcc_pkg::CH_RUN;
					next_chan[i].count    = load_reg[i];
					next_chan[i].alt_hold = 1'h0;
					next_chan[i].end_seen = 1'h0;
				end
				// repeat mode only ever disarms here
				if (disarm_wr[i]) begin
					next_chan[i].state = mmcc_pkg::CH_IDLE;
				end
			end

			// channel state, one 16-bit count each
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chan[i] <= mmcc_pkg::CHAN_RST;
				end else if (ce) begin
					chan[i] <= next_chan[i];
				end
			end

			AST_COUNT_STEP: assert property (
				accept[i] && !end_hit[i] && !sw
				|=> chan[i].count == $past(chan[i].count) - mmcc_pkg::CNT_STEP)
				else $error("count did not step down by one");

			AST_ONCE_DISARM: assert property (
				end_hit[i] && !rep && !rsel && !sw
				|=> chan[i].state == mmcc_pkg::CH_IDLE)
				else $error("single-shot mode did not disarm");

			AST_TWICE_DISARM: assert property (
				end_hit[i] && !rep && rsel && !sw
				|=> (chan[i].state == mmcc_pkg::CH_IDLE)
					== $past(chan[i].end_seen))
				else $error("two-shot mode disarmed at wrong count");

			AST_REPEAT_ARMED: assert property (
				rep && armed[i] && !disarm_wr[i] |=> armed[i])
				else $error("repeat mode disarmed by itself");

			AST_NO_GATE: assert property (
				ce && gsel == mmcc_pkg::GATE_NONE && running[i] && src_edge
				&& chan[i].count != mmcc_pkg::END_VALUE && !sw
				|=> chan[i].count != $past(chan[i].count))
				else $error("ungated channel missed a count edge");

			AST_LEVEL_HOLD: assert property (
				gsel == mmcc_pkg::GATE_LEVEL && !gate_in[i] && !sw
				|=> $stable(chan[i].count))
				else $error("level-gated channel counted with gate low");

			AST_EDGE_START: assert property (
				ce && gsel == mmcc_pkg::GATE_EDGE && gate_edge && !sw
				&& chan[i].state == mmcc_pkg::CH_WAIT
				|=> running[i])
				else $error("gate edge did not start counting");

			AST_EDGE_STOP1: assert property (
				end_hit[i] && gsel == mmcc_pkg::GATE_EDGE && !rsel && !sw
				|=> !running[i])
				else $error("edge gating did not stop on next count end");

			AST_EDGE_STOP2: assert property (
				end_hit[i] && gsel == mmcc_pkg::GATE_EDGE && rsel && !sw
				|=> running[i] == !$past(chan[i].end_seen))
				else $error("edge gating did not stop on second count end");

			AST_RELOAD_LOAD: assert property (
				end_hit[i] && !rsel && !sw
				|=> chan[i].count == $past(load_reg[i]))
				else $error("reload did not take the load register");

			AST_RELOAD_ALT: assert property (
				end_hit[i] && rsel && !sw
				|=> chan[i].count == ($past(chan[i].alt_hold) ?
					$past(load_reg[i]) : $past(hold_reg[i]))
					&& chan[i].alt_hold != $past(chan[i].alt_hold))
				else $error("alternating reload took the wrong register");

			AST_END_FLAG: assert property (
				end_hit[i] |=> end_status[i] && end_pulse[i]
				##1 !end_pulse[i] || $past(end_hit[i]))
				else $error("count end not flagged");

			COV_ONCE: cover property (
				end_hit[i] && !rep && !rsel ##1 !armed[i]);
			COV_TWICE: cover property (
				end_hit[i] && rsel && !rep && chan[i].end_seen);
			COV_EDGE_START: cover property (
				chan[i].state == mmcc_pkg::CH_WAIT ##1 running[i]);
		end
	endgenerate

	// an unmasked count end must raise the line on the following cycle
	AST_IRQ_LEVEL: assert property (
		|(end_hit & end_mask) && !(wr_ok && paddr == mmcc_pkg::OFS_MASK)
		|=> irq)
		else $error("interrupt not raised for an unmasked flag");

	COV_IRQ: cover property (!irq ##1 irq);
endmodule

// [test/mmcc_pins_model.sv]
module mmcc_pins_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [7:0] go,
	input  wire logic       slow,
	input  wire logic [7:0] gate_set,
	output logic      [7:0] cnt_src,
	output logic      [7:0] gate_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ph;

	// pace divider: slow mode halves the source rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph <= 1'b0;
		end else begin
			ph <= ~ph;
		end
	end

	// toggling at most every pclk keeps each level at least one cycle wide
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_src <= 8'h00;
		end else begin
			cnt_src <= go & (cnt_src ^ {8{~slow | ph}});
		end
	end

	// gate acts like a registered pin, one cycle behind the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_in <= 8'h00;
		end else begin
			gate_in <= gate_set;
		end
	end
endmodule

// [test/test_multi_mode_counter_channel.sv]
module test_multi_mode_counter_channel;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_CTRL = 8'h80;
	localparam logic [7:0] A_STAT = 8'h84;
	localparam logic [7:0] A_MASK = 8'h88;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        irq, slow, e, ce;
	logic [7:0]  paddr, cnt_src, gate_in, end_pulse, go, gate_set, end_seen;
	logic [31:0] pwdata, prdata, r;
	int          bad_count, total_checks;

	mmcc_counter dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cnt_src(cnt_src), .gate_in(gate_in),
		.end_pulse(end_pulse), .irq(irq));
	mmcc_pins_model pins_u (.pclk(pclk), .presetn(presetn), .go(go),
		.slow(slow), .gate_set(gate_set), .cnt_src(cnt_src),
		.gate_in(gate_in));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// sticky copy so a one-cycle pulse cannot slip between reads
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			end_seen <= 8'h00;
		end else begin
			end_seen <= end_seen | end_pulse;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one transfer; waits on pready with a bound, releases after it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		if (n >= 50) bad_count++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask

	// n rising source edges on the channels in m
	task automatic edges(input logic [7:0] m, input int n);
		go <= m;
		repeat (slow ? 4 * n : 2 * n) @(posedge pclk);
		go <= 8'h00;
		repeat (3) @(posedge pclk);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		bad_count++;
		test_done();
	end

	initial begin
		{presetn, psel, penable, pwrite, slow} = 5'h00;
		{paddr, go, gate_set} = 24'h0;
		ce = 1'b1;
		pwdata = 32'h0;
		bad_count = 0;
		total_checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(A_STAT, 32'h0);
		rd(8'h00, 32'h0);
		apb(1'b0, 8'h90, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test reset and unmapped done");
		apb(1'b1, A_MASK, 32'h1);
		apb(1'b1, 8'h04, 32'h3);
		apb(1'b1, A_CTRL, 32'h1);
		rd(A_CTRL, 32'h101);
		edges(8'h01, 3);
		rd(8'h0C, 32'h3);
		rd(A_CTRL, 32'h0);
		rd(A_STAT, 32'h1);
		chk({31'h0, irq}, 32'h1);
		chk({24'h0, end_seen}, 32'h1);
		apb(1'b1, A_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		$display("test single pass done");
		apb(1'b1, 8'h00, 32'h20);
		apb(1'b1, 8'h08, 32'h3);
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b1, A_CTRL, 32'h1);
		edges(8'h01, 2);
		rd(8'h0C, 32'h3);
		rd(A_CTRL, 32'h101);
		edges(8'h01, 3);
		rd(8'h0C, 32'h2);
		rd(A_CTRL, 32'h0);
		apb(1'b1, A_STAT, 32'h1);
		$display("test double pass done");
		slow <= 1'b1;
		apb(1'b1, 8'h70, 32'h10);
		apb(1'b1, 8'h74, 32'h2);
		apb(1'b1, A_CTRL, 32'h80);
		edges(8'h80, 5);
		rd(8'h7C, 32'h1);
		rd(A_CTRL, 32'h8080);
		rd(A_STAT, 32'h80);
		chk({31'h0, irq}, 32'h0);
		chk({24'h0, end_seen}, 32'h81);
		apb(1'b1, A_CTRL, 32'h8000);
		apb(1'b1, A_STAT, 32'h80);
		slow <= 1'b0;
		$display("test repeat done");
		apb(1'b1, 8'h00, 32'h1010);
		apb(1'b1, 8'h04, 32'h3);
		apb(1'b1, A_CTRL, 32'h1);
		edges(8'h01, 2);
		rd(8'h0C, 32'h3);
		gate_set <= 8'h01;
		edges(8'h01, 2);
		rd(8'h0C, 32'h1);
		gate_set <= 8'h00;
		apb(1'b1, A_CTRL, 32'h100);
		$display("test level gate done");
		apb(1'b1, 8'h00, 32'h2000);
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b1, A_CTRL, 32'h1);
		rd(A_CTRL, 32'h1);
		edges(8'h01, 2);
		rd(8'h0C, 32'h2);
		gate_set <= 8'h01;
		repeat (3) @(posedge pclk);
		rd(A_CTRL, 32'h101);
		edges(8'h01, 2);
		rd(A_CTRL, 32'h0);
		rd(8'h0C, 32'h2);
		gate_set <= 8'h00;
		apb(1'b1, 8'h00, 32'h2020);
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, A_CTRL, 32'h1);
		gate_set <= 8'h01;
		repeat (3) @(posedge pclk);
		edges(8'h01, 1);
		rd(A_CTRL, 32'h101);
		edges(8'h01, 1);
		rd(A_CTRL, 32'h0);
		$display("test edge gate done");
		// edge gating with repeat: a count end parks the channel armed
		apb(1'b1, 8'h00, 32'h2010);
		apb(1'b1, A_CTRL, 32'h1);
		rd(A_CTRL, 32'h1);
		gate_set <= 8'h00;
		repeat (3) @(posedge pclk);
		gate_set <= 8'h01;
		repeat (3) @(posedge pclk);
		rd(A_CTRL, 32'h101);
		edges(8'h01, 1);
		rd(A_CTRL, 32'h1);
		rd(8'h0C, 32'h1);
		apb(1'b1, A_CTRL, 32'h100);
		apb(1'b1, A_STAT, 32'h1);
		$display("test edge repeat done");
		// clock enable low must freeze the count and edge history
		apb(1'b1, 8'h00, 32'h10);
		apb(1'b1, 8'h04, 32'h3);
		apb(1'b1, A_CTRL, 32'h1);
		ce <= 1'b0;
		edges(8'h01, 2);
		ce <= 1'b1;
		rd(8'h0C, 32'h3);
		edges(8'h01, 1);
		rd(8'h0C, 32'h2);
		apb(1'b1, A_CTRL, 32'h100);
		$display("test clock enable done");
		test_done();
	end
endmodule
